// [bench/bit_ops_call_return_exec_test.sv]
`timescale 1ns/10ps
`default_nettype none
module bit_ops_call_return_exec_test;
   localparam logic [4:0] WAIT = 5'h03;
   logic clock = 1'b0, resetn = 1'b0, start = 1'b0, extFetch = 1'b0, setupLoad = 1'b0;
   boc_pkg::boc_op_type   opcode = boc_pkg::BOC_POP_PC_BACK;
   boc_pkg::boc_form_type form = boc_pkg::BOC_FORM_ACC;
   logic [2:0]  bitSel = 3'h0;
   logic [7:0]  operandByte = 8'h00, vectorEntry = 8'h00, setupAcc = 8'h00, setupPsw = 8'h00;
   logic [7:0]  memReadData = 8'h00;
   logic [15:0] addr16 = 16'h0000, setupPc = 16'h0000, setupSp = 16'h0000, pointerPair = 16'hfd00;
   logic [10:0] addr11 = 11'h000;
   wire logic   memRead, memWrite, busy, done, carryFlag, interruptEnable;
   wire logic [15:0] memAddr, pc, sp;
   wire logic [7:0]  memWriteData, acc, program_status_word;
   logic [7:0]  mem [0:65535];
   int          fails = 0, comparisons = 0, n;
   boc_exec_unit #(.EXT_FETCH_WAIT(WAIT)) uut (.*);
   always #50 clock = ~clock;
   // data memory; no read shows the inverse, so stale data never passes
   always @(posedge clock) begin
      if (memWrite) mem[memAddr] <= memWriteData;
      memReadData <= memRead ? mem[memAddr] : ~memReadData;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic complete_run;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : complete_run
   task automatic setup(input logic [15:0] p, input logic [15:0] s, input logic [7:0] w);
      @(posedge clock);
      setupLoad <= 1'b1; setupPc <= p; setupSp <= s; setupAcc <= 8'h5a; setupPsw <= w;
      @(posedge clock);
      setupLoad <= 1'b0;
   endtask : setup
   // issue, then count edges to the done pulse
   task automatic issue(input boc_pkg::boc_op_type op, input logic [15:0] t = 16'h0000,
                        input boc_pkg::boc_form_type f = boc_pkg::BOC_FORM_ACC,
                        input logic [7:0] ob = 8'h00, input logic [2:0] b = 3'h0);
      @(posedge clock);
      start <= 1'b1; opcode <= op; form <= f; operandByte <= ob; bitSel <= b;
      addr16 <= t; addr11 <= t[10:0]; vectorEntry <= t[7:0];
      @(posedge clock);
      start <= 1'b0;
      n = 0;
      while (n < 40) begin
         @(posedge clock);
         n++;
         #1;
         if (done === 1'b1) break;
      end
   endtask : issue
   ////////////////////////////////////////////////////////////////////////
   task automatic t_bits;
      setup(16'h0100, 16'hfe1f, 8'h03);
      issue(boc_pkg::BOC_CARRY_BIT_AND);
      chk(n, 32'h4);
      chk(carryFlag, 1'b0);
      issue(boc_pkg::BOC_CARRY_BIT_OR, 16'h0000, boc_pkg::BOC_FORM_ACC, 8'h00, 3'h1);
      chk(carryFlag, 1'b1);
      issue(boc_pkg::BOC_CARRY_BIT_EXCLUSIVE, 16'h0000, boc_pkg::BOC_FORM_ACC, 8'h00, 3'h6);
      chk(carryFlag, 1'b0);
      chk(pc, 16'h0106);
      mem[16'hfe40] = 8'h08;
      mem[16'hff10] = 8'h02;
      issue(boc_pkg::BOC_CARRY_FORCE_HIGH);
      chk(n, 32'h2);
      issue(boc_pkg::BOC_CARRY_BIT_AND, 16'h0000, boc_pkg::BOC_FORM_SADDR, 8'h40, 3'h3);
      chk({16'(n), 15'h0, carryFlag}, {16'h0006, 16'h0001});
      issue(boc_pkg::BOC_CARRY_BIT_AND, 16'h0000, boc_pkg::BOC_FORM_SADDR, 8'h10, 3'h0);
      chk({16'(n), 15'h0, carryFlag}, {16'h0007, 16'h0000});
      issue(boc_pkg::BOC_CARRY_BIT_EXCLUSIVE, 16'h0000, boc_pkg::BOC_FORM_SFR, 8'h10, 3'h1);
      chk({16'(n), 15'h0, carryFlag}, {16'h0007, 16'h0001});
      issue(boc_pkg::BOC_BIT_FORCE_HIGH, 16'h0000, boc_pkg::BOC_FORM_SADDR, 8'h40, 3'h0);
      chk({16'(n), 8'h0, mem[16'hfe40]}, {16'h0004, 16'h0009});
      issue(boc_pkg::BOC_BIT_FORCE_LOW, 16'h0000, boc_pkg::BOC_FORM_SADDR, 8'h10, 3'h1);
      chk({16'(n), 8'h0, mem[16'hff10]}, {16'h0006, 16'h0000});
      @(posedge clock);
      extFetch <= 1'b1;
      issue(boc_pkg::BOC_CARRY_INVERT);
      chk(n, 32'h2 + WAIT);
      @(posedge clock) extFetch <= 1'b0;
      $display("bit tests finished");
   endtask : t_bits
   task automatic t_calls;
      setup(16'h1234, 16'hfe1f, 8'h83);
      issue(boc_pkg::BOC_ABSOLUTE_CALL, 16'h4567);
      chk({mem[16'hfe1e], mem[16'hfe1d]}, 16'h1237);
      chk(sp, 16'hfe1d);
      issue(boc_pkg::BOC_SHORT_PAGE_CALL, 16'h0123);
      chk({mem[16'hfe1c], mem[16'hfe1b]}, 16'h4569);
      chk(pc, 16'h0923);
      mem[16'h0040] = 8'hcd;
      mem[16'h0041] = 8'hab;
      issue(boc_pkg::BOC_VECTOR_TABLE_CALL, 16'h0040);
      chk({mem[16'hfe1a], mem[16'hfe19]}, 16'h0924);
      chk(pc, 16'habcd);
      mem[16'h003e] = 8'hef;
      mem[16'h003f] = 8'hbe;
      issue(boc_pkg::BOC_SOFTWARE_BREAK_TRAP);
      chk({mem[16'hfe18], mem[16'hfe17]}, 16'h83ab);
      chk(pc, 16'hbeef);
      chk({15'h0, interruptEnable}, 16'h0000);
      issue(boc_pkg::BOC_POP_PC_BACK);
      chk(n, 32'h6);
      chk(pc, 16'habce);
      $display("call tests finished");
   endtask : t_calls
   // watchdog: the tests need well under a thousand cycles
   initial begin
      #500000;
      fails++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      t_bits();
      t_calls();
      complete_run();
   end
endmodule : bit_ops_call_return_exec_test
`default_nettype wire

// [bench/boc_exec_unit_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module boc_exec_unit_asserts (
   // issue side
   input wire logic                  clock,
   input wire logic                  resetn,
   input wire logic                  start,
   input wire logic                  setupLoad,
   input wire logic                  extFetch,
   input wire boc_pkg::boc_op_type   opcode,
   input wire boc_pkg::boc_form_type form,
   input wire logic [15:0]           addr16,
   input wire logic [10:0]           addr11,
   // memory and state
   input wire logic                  memWrite,
   input wire logic [15:0]           memAddr,
   input wire logic [7:0]            memWriteData,
   input wire logic                  busy,
   input wire logic                  done,
   input wire logic [15:0]           pc,
   input wire logic [15:0]           sp,
   input wire logic [7:0]            program_status_word,
   input wire logic                  carryFlag,
   input wire logic                  interruptEnable
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // accepted issue; no fetch wait or preload, so counts are fixed
   wire logic taken = start && !busy && !extFetch && !setupLoad;
   ////////////////////////////////////////////////////////////////////////
   AST_DONE_ONE: assert property (done |=> !done && busy == $past(start))
      else $error("done pulse too long");
   AST_LOGIC_ACC: assert property (taken && opcode == boc_pkg::BOC_CARRY_BIT_AND
      && form == boc_pkg::BOC_FORM_ACC |=> busy [*4] ##1 done) else $error("acc logic count");
   AST_CALL_TIME: assert property (taken && opcode == boc_pkg::BOC_ABSOLUTE_CALL
      |=> busy [*7] ##1 done) else $error("call count");
   AST_CALL_PC: assert property (taken && opcode == boc_pkg::BOC_ABSOLUTE_CALL |-> ##8
      pc == $past(addr16, 8) && sp == $past(sp, 8) - 16'h0002) else $error("call target");
   AST_PAGE_PC: assert property (taken && opcode == boc_pkg::BOC_SHORT_PAGE_CALL |-> ##6
      done && pc == {5'h01, $past(addr11, 6)}) else $error("page call target");
   AST_BRK_PSW: assert property (taken && opcode == boc_pkg::BOC_SOFTWARE_BREAK_TRAP
      |-> ##3 memWrite && memAddr == $past(sp, 3) - 16'h0001 && memWriteData == $past(program_status_word, 3))
      else $error("break status push");
   AST_BRK_IE: assert property (taken && opcode == boc_pkg::BOC_SOFTWARE_BREAK_TRAP
      |-> ##7 done && !interruptEnable && sp == $past(sp, 7) - 16'h0003) else $error("break");
   AST_RET_SP: assert property (taken && opcode == boc_pkg::BOC_POP_PC_BACK |-> ##7
      done && sp == $past(sp, 7) + 16'h0002) else $error("return stack");
   AST_INV_CARRY: assert property (taken && opcode == boc_pkg::BOC_CARRY_INVERT |-> ##3
      done && carryFlag != $past(carryFlag, 3)) else $error("carry invert");
endmodule : boc_exec_unit_asserts
bind boc_exec_unit boc_exec_unit_asserts chk (.clock(clock), .resetn(resetn), .start(start),
   .setupLoad(setupLoad), .extFetch(extFetch), .opcode(opcode), .form(form), .addr16(addr16),
   .addr11(addr11), .memWrite(memWrite), .memAddr(memAddr), .memWriteData(memWriteData),
   .busy(busy), .done(done), .pc(pc), .sp(sp), .program_status_word(program_status_word), .carryFlag(carryFlag),
   .interruptEnable(interruptEnable));
`default_nettype wire

// [logic/boc_bit_unit.sv]
`timescale 1ns/10ps
`default_nettype none
`include "boc_params.svh"

module boc_bit_unit (
   // operation and operands
   input  wire boc_pkg::boc_op_type op,
   input  wire logic                carry,
   input  wire logic [7:0]          source,
   input  wire logic [2:0]          bitSel,
   // results
   output logic                     newCarry,
   output logic [7:0]               newByte
);

   logic [7:0] mask;
   logic       picked;

   assign mask   = 8'h01 << bitSel;
   assign picked = source[bitSel];

   // carry result; the chosen byte itself is never altered by these
   always_comb begin
      case (op)
         boc_pkg::BOC_CARRY_BIT_AND:       newCarry = carry & picked;
         boc_pkg::BOC_CARRY_BIT_OR:        newCarry = carry | picked;
         boc_pkg::BOC_CARRY_BIT_EXCLUSIVE: newCarry = carry ^ picked;
         boc_pkg::BOC_CARRY_FORCE_HIGH:    newCarry = 1'b1;
         boc_pkg::BOC_CARRY_FORCE_LOW:     newCarry = 1'b0;
         boc_pkg::BOC_CARRY_INVERT:        newCarry = ~carry;
         default:                          newCarry = carry;
      endcase
   end

   // forced byte, other bits kept
   always_comb begin
      case (op)
         boc_pkg::BOC_BIT_FORCE_HIGH: newByte = source | mask;
         boc_pkg::BOC_BIT_FORCE_LOW:  newByte = source & ~mask;
         default:                     newByte = source;
      endcase
   end

endmodule : boc_bit_unit
`default_nettype wire

// [logic/boc_cycle_count.sv]
`timescale 1ns/10ps
`default_nettype none
`include "boc_params.svh"

module boc_cycle_count (
   // decoded instruction
   input  wire boc_pkg::boc_op_type   op,
   input  wire boc_pkg::boc_form_type form,
   input  wire logic                  fastArea,
   // results
   output logic [4:0]                 cycles,
   output logic [1:0]                 length
);

   // clock count and byte length per instruction and operand form
   always_comb begin
      cycles = `BOC_CLK_SIX;
      length = 2'h1;
      case (op)
         boc_pkg::BOC_CARRY_BIT_AND, boc_pkg::BOC_CARRY_BIT_OR,
         boc_pkg::BOC_CARRY_BIT_EXCLUSIVE: begin
            length = (form == boc_pkg::BOC_FORM_ACC || form == boc_pkg::BOC_FORM_HL) ?
                     2'h2 : 2'h3;
            if (form == boc_pkg::BOC_FORM_ACC) cycles = `BOC_CLK_LOGIC_ACC;
            else if (form == boc_pkg::BOC_FORM_SFR || form == boc_pkg::BOC_FORM_PSW)
               cycles = `BOC_CLK_LOGIC_SLOW;
            else cycles = fastArea ? `BOC_CLK_LOGIC_DIR : `BOC_CLK_LOGIC_SLOW;
         end
         boc_pkg::BOC_BIT_FORCE_HIGH, boc_pkg::BOC_BIT_FORCE_LOW: begin
            length = (form == boc_pkg::BOC_FORM_SFR) ? 2'h3 : 2'h2;
            case (form)
               boc_pkg::BOC_FORM_SADDR:
                  cycles = fastArea ? `BOC_CLK_FORCE_DIR : `BOC_CLK_FORCE_SLOW;
               boc_pkg::BOC_FORM_SFR: cycles = `BOC_CLK_FORCE_SFR;
               boc_pkg::BOC_FORM_ACC: cycles = `BOC_CLK_FORCE_DIR;
               boc_pkg::BOC_FORM_PSW: cycles = `BOC_CLK_FORCE_SLOW;
               default: cycles = fastArea ? `BOC_CLK_FORCE_HL : `BOC_CLK_FORCE_HLS;
            endcase
         end
         boc_pkg::BOC_CARRY_FORCE_HIGH, boc_pkg::BOC_CARRY_FORCE_LOW,
         boc_pkg::BOC_CARRY_INVERT: cycles = `BOC_CLK_CARRY;
         boc_pkg::BOC_ABSOLUTE_CALL: begin
            cycles = `BOC_CLK_CALL;
            length = 2'h3;
         end
         boc_pkg::BOC_SHORT_PAGE_CALL: begin
            cycles = `BOC_CLK_PAGE_CALL;
            length = 2'h2;
         end
         default: cycles = `BOC_CLK_SIX;
      endcase
   end

endmodule : boc_cycle_count
`default_nettype wire

// [logic/boc_exec_unit.sv]
// Overview of operation
// - one timing cycle is one clock period
// - fast RAM or no access: first count
// - other areas use the second count
// - counts hold for internal program memory
// - carry becomes carry AND chosen bit
// - carry becomes carry OR chosen bit
// - carry becomes carry XOR chosen bit
// - AND/OR/XOR register and status bit forms: 7 clocks
// - absolute call pushes return high then low
// - absolute call loads target, stack minus two
// - page call pushes next address
// - page call sets upper bits 00001
// - table call loads target from page zero
// - break pushes status, then return address
// - break loads vector from 003e/003f
// - break drops stack three, clears enable
// - return pops address, stack plus two
`timescale 1ns/10ps
`default_nettype none
`include "boc_params.svh"

module boc_exec_unit #(
   parameter logic [15:0] FAST_RAM_LO  = 16'hfb00,
   parameter logic [15:0] FAST_RAM_HI  = 16'hfeff,
   parameter logic [4:0]  EXT_FETCH_WAIT = 5'h02
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  resetn,
   // instruction issue
   input  wire logic                  start,
   input  wire boc_pkg::boc_op_type   opcode,
   input  wire boc_pkg::boc_form_type form,
   input  wire logic [2:0]            bitSel,
   input  wire logic [7:0]            operandByte,
   input  wire logic [15:0]           pointerPair,
   input  wire logic [15:0]           addr16,
   input  wire logic [10:0]           addr11,
   input  wire logic [7:0]            vectorEntry,
   input  wire logic                  extFetch,
   // architectural state preload
   input  wire logic                  setupLoad,
   input  wire logic [15:0]           setupPc,
   input  wire logic [15:0]           setupSp,
   input  wire logic [7:0]            setupAcc,
   input  wire logic [7:0]            setupPsw,
   // data memory
   output logic                       memRead,
   output logic                       memWrite,
   output logic [15:0]                memAddr,
   output logic [7:0]                 memWriteData,
   input  wire logic [7:0]            memReadData,
   // status
   output logic                       busy,
   output logic                       done,
   output logic [15:0]                pc,
   output logic [15:0]                sp,
   output logic [7:0]                 acc,
   output logic [7:0]                 program_status_word,
   output logic                       carryFlag,
   output logic                       interruptEnable
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   boc_pkg::boc_state_type state;
   boc_pkg::boc_op_type    op;
   boc_pkg::boc_form_type  opForm;
   logic [4:0]             step;
   logic [4:0]             lastStep;
   logic [2:0]             bitIdx;
   logic [15:0]            dataAddr;
   logic [15:0]            jumpAddr;
   logic [15:0]            nextPc;
   logic [7:0]             lowByte;
   logic [7:0]             highByte;
   logic [15:0]            issueAddr;
   logic                   issueFast;
   logic [4:0]             issueCycles;
   logic [1:0]             issueLength;
   logic                   memForm;
   logic                   commit;
   logic [7:0]             unitSource;
   logic                   unitCarry;
   logic [7:0]             unitByte;
   logic                   accept;

   assign carryFlag       = program_status_word[`BOC_PSW_CY];
   assign interruptEnable = program_status_word[`BOC_PSW_IE];
   assign busy            = (state == boc_pkg::BOC_RUN);
   assign accept          = start && (state == boc_pkg::BOC_IDLE);
   assign commit          = busy && (step == lastStep);
   assign memForm         = (opForm == boc_pkg::BOC_FORM_SADDR) ||
                            (opForm == boc_pkg::BOC_FORM_SFR) ||
                            (opForm == boc_pkg::BOC_FORM_HL);

   ////////////////////////////////////////////////////////////////////////////
   // operand address at issue

   // short-direct offsets below the wrap point fall in the register window
   always_comb begin
      case (form)
         boc_pkg::BOC_FORM_SADDR:
            issueAddr = (operandByte < `BOC_SADDR_WRAP) ?
                        (`BOC_SFR_BASE | {8'h00, operandByte}) :
                        (`BOC_SADDR_BASE | {8'h00, operandByte});
         boc_pkg::BOC_FORM_SFR: issueAddr = `BOC_SFR_BASE | {8'h00, operandByte};
         boc_pkg::BOC_FORM_HL:  issueAddr = pointerPair;
         default:               issueAddr = 16'h0000;
      endcase
   end

   // accumulator forms and calls count as no data access, registers as slow
   always_comb begin
      case (form)
         boc_pkg::BOC_FORM_SADDR, boc_pkg::BOC_FORM_HL:
            issueFast = (issueAddr >= FAST_RAM_LO) && (issueAddr <= FAST_RAM_HI);
         boc_pkg::BOC_FORM_ACC: issueFast = 1'b1;
         default:               issueFast = 1'b0;
      endcase
   end

   boc_cycle_count u_count (
      .op       (opcode),
      .form     (form),
      .fastArea (issueFast),
      .cycles   (issueCycles),
      .length   (issueLength)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   // one step per clock; fetching from outside program memory stretches the run
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state    <= boc_pkg::BOC_IDLE;
         step     <= 5'h00;
         lastStep <= 5'h00;
      end else begin
         case (state)
            boc_pkg::BOC_IDLE: begin
               step <= 5'h00;
               if (accept) begin
                  state    <= boc_pkg::BOC_RUN;
                  lastStep <= extFetch ? issueCycles - 5'h01 + EXT_FETCH_WAIT :
                                         issueCycles - 5'h01;
               end
            end
            boc_pkg::BOC_RUN: begin
               if (commit) begin
                  state <= boc_pkg::BOC_IDLE;
                  step  <= 5'h00;
               end else begin
                  step <= step + 5'h01;
               end
            end
            default: begin
               state <= boc_pkg::BOC_IDLE;
               step  <= 5'h00;
            end
         endcase
      end
   end

   // instruction fields held for the whole run
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         op       <= boc_pkg::BOC_CARRY_INVERT;
         opForm   <= boc_pkg::BOC_FORM_ACC;
         bitIdx   <= 3'h0;
         dataAddr <= 16'h0000;
         jumpAddr <= 16'h0000;
         nextPc   <= 16'h0000;
      end else if (accept) begin
         op       <= opcode;
         opForm   <= form;
         bitIdx   <= bitSel;
         nextPc   <= pc + {14'h0000, issueLength};
         case (opcode)
            boc_pkg::BOC_ABSOLUTE_CALL:     jumpAddr <= addr16;
            boc_pkg::BOC_SHORT_PAGE_CALL:   jumpAddr <= {`BOC_PAGE_CALL_HI, addr11};
            boc_pkg::BOC_VECTOR_TABLE_CALL: jumpAddr <= {8'h00, vectorEntry};
            default:                        jumpAddr <= 16'h0000;
         endcase
         dataAddr <= issueAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data memory sequence
   // reads always sit in steps 0 and 1 so that the two bytes are in hand
   // before any push; memory answers a read on the following clock

   always_comb begin
      memRead      = 1'b0;
      memWrite     = 1'b0;
      memAddr      = 16'h0000;
      memWriteData = 8'h00;
      if (busy) begin
         case (op)
            boc_pkg::BOC_CARRY_BIT_AND, boc_pkg::BOC_CARRY_BIT_OR,
            boc_pkg::BOC_CARRY_BIT_EXCLUSIVE: begin
               memRead = memForm && (step == 5'h00);
               memAddr = dataAddr;
            end
            boc_pkg::BOC_BIT_FORCE_HIGH, boc_pkg::BOC_BIT_FORCE_LOW: begin
               memRead      = memForm && (step == 5'h00);
               memWrite     = memForm && (step == 5'h01);
               memAddr      = dataAddr;
               memWriteData = unitByte;
            end
            boc_pkg::BOC_ABSOLUTE_CALL, boc_pkg::BOC_SHORT_PAGE_CALL: begin
               memWrite     = (step == 5'h00) || (step == 5'h01);
               memAddr      = (step == 5'h00) ? sp - 16'h0001 : sp - 16'h0002;
               memWriteData = (step == 5'h00) ? nextPc[15:8] : nextPc[7:0];
            end
            boc_pkg::BOC_VECTOR_TABLE_CALL: begin
               memRead      = (step == 5'h00) || (step == 5'h01);
               memWrite     = (step == 5'h02) || (step == 5'h03);
               memWriteData = (step == 5'h02) ? nextPc[15:8] : nextPc[7:0];
               case (step)
                  5'h00:   memAddr = jumpAddr;
                  5'h01:   memAddr = jumpAddr + 16'h0001;
                  5'h02:   memAddr = sp - 16'h0001;
                  default: memAddr = sp - 16'h0002;
               endcase
            end
            boc_pkg::BOC_SOFTWARE_BREAK_TRAP: begin
               memRead  = (step == 5'h00) || (step == 5'h01);
               memWrite = (step == 5'h02) || (step == 5'h03) || (step == 5'h04);
               case (step)
                  5'h00: memAddr = `BOC_BRK_VEC_LO;
                  5'h01: memAddr = `BOC_BRK_VEC_HI;
                  5'h02: begin
                     memAddr      = sp - 16'h0001;
                     memWriteData = program_status_word;
                  end
                  5'h03: begin
                     memAddr      = sp - 16'h0002;
                     memWriteData = nextPc[15:8];
                  end
                  default: begin
                     memAddr      = sp - 16'h0003;
                     memWriteData = nextPc[7:0];
                  end
               endcase
            end
            boc_pkg::BOC_POP_PC_BACK: begin
               memRead = (step == 5'h00) || (step == 5'h01);
               memAddr = (step == 5'h00) ? sp : sp + 16'h0001;
            end
            default: memAddr = 16'h0000;
         endcase
      end
   end

   // read bytes: the first arrives in step 1, the second in step 2
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lowByte  <= 8'h00;
         highByte <= 8'h00;
      end else if (busy) begin
         if (step == 5'h01) lowByte <= memReadData;
         if (step == 5'h02) highByte <= memReadData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit operand selection

   // the write-back of a forced memory bit uses the byte still on the bus
   always_comb begin
      case (opForm)
         boc_pkg::BOC_FORM_ACC: unitSource = acc;
         boc_pkg::BOC_FORM_PSW: unitSource = program_status_word;
         default:               unitSource = (step == 5'h01) ? memReadData : lowByte;
      endcase
   end

   boc_bit_unit u_bits (
      .op       (op),
      .carry    (program_status_word[`BOC_PSW_CY]),
      .source   (unitSource),
      .bitSel   (bitIdx),
      .newCarry (unitCarry),
      .newByte  (unitByte)
   );

   ////////////////////////////////////////////////////////////////////////////
   // architectural registers, updated on the last step only

   // program counter
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pc <= `BOC_RESET_PC;
      end else if (setupLoad && !busy) begin
         pc <= setupPc;
      end else if (commit) begin
         case (op)
            boc_pkg::BOC_ABSOLUTE_CALL, boc_pkg::BOC_SHORT_PAGE_CALL:
               pc <= jumpAddr;
            boc_pkg::BOC_VECTOR_TABLE_CALL, boc_pkg::BOC_SOFTWARE_BREAK_TRAP,
            boc_pkg::BOC_POP_PC_BACK:
               pc <= {highByte, lowByte};
            default: pc <= nextPc;
         endcase
      end
   end

   // stack pointer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sp <= `BOC_RESET_SP;
      end else if (setupLoad && !busy) begin
         sp <= setupSp;
      end else if (commit) begin
         case (op)
            boc_pkg::BOC_ABSOLUTE_CALL, boc_pkg::BOC_SHORT_PAGE_CALL,
            boc_pkg::BOC_VECTOR_TABLE_CALL:
               sp <= sp - 16'h0002;
            boc_pkg::BOC_SOFTWARE_BREAK_TRAP: sp <= sp - 16'h0003;
            boc_pkg::BOC_POP_PC_BACK:         sp <= sp + 16'h0002;
            default:                          sp <= sp;
         endcase
      end
   end

   // accumulator, touched only by forced bits in the accumulator
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         acc <= 8'h00;
      end else if (setupLoad && !busy) begin
         acc <= setupAcc;
      end else if (commit && opForm == boc_pkg::BOC_FORM_ACC &&
                   (op == boc_pkg::BOC_BIT_FORCE_HIGH || op == boc_pkg::BOC_BIT_FORCE_LOW)) begin
         acc <= unitByte;
      end
   end

   // status word; forcing one of its bits may move zero, aux carry or carry
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         program_status_word <= `BOC_RESET_PSW;
      end else if (setupLoad && !busy) begin
         program_status_word <= setupPsw;
      end else if (commit) begin
         case (op)
            boc_pkg::BOC_CARRY_BIT_AND, boc_pkg::BOC_CARRY_BIT_OR,
            boc_pkg::BOC_CARRY_BIT_EXCLUSIVE, boc_pkg::BOC_CARRY_FORCE_HIGH,
            boc_pkg::BOC_CARRY_FORCE_LOW, boc_pkg::BOC_CARRY_INVERT:
               program_status_word[`BOC_PSW_CY] <= unitCarry;
            boc_pkg::BOC_BIT_FORCE_HIGH, boc_pkg::BOC_BIT_FORCE_LOW:
               if (opForm == boc_pkg::BOC_FORM_PSW) program_status_word <= unitByte;
            boc_pkg::BOC_SOFTWARE_BREAK_TRAP:
               program_status_word[`BOC_PSW_IE] <= 1'b0;
            default: program_status_word <= program_status_word;
         endcase
      end
   end

   // completion pulse in the cycle after the last step
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
      end else begin
         done <= commit;
      end
   end

endmodule : boc_exec_unit
`default_nettype wire

// [logic/boc_params.svh]
`ifndef BOC_PARAMS_SVH
`define BOC_PARAMS_SVH

// short-direct and special-function address windows
`define BOC_SADDR_BASE      16'hfe00
`define BOC_SFR_BASE        16'hff00
`define BOC_SADDR_WRAP      8'h20
// break trap vector locations
`define BOC_BRK_VEC_LO      16'h003e
`define BOC_BRK_VEC_HI      16'h003f
// program status word field positions
`define BOC_PSW_IE          7
`define BOC_PSW_CY          0
// reset values
`define BOC_RESET_PC        16'h0000
`define BOC_RESET_SP        16'hfe1f
`define BOC_RESET_PSW       8'h02
// short-page call upper program counter bits
`define BOC_PAGE_CALL_HI    5'h01
// clock counts: first value = high-speed RAM or no access, second = other areas
`define BOC_CLK_LOGIC_DIR   5'h06
`define BOC_CLK_LOGIC_SLOW  5'h07
`define BOC_CLK_LOGIC_ACC   5'h04
`define BOC_CLK_FORCE_DIR   5'h04
`define BOC_CLK_FORCE_SLOW  5'h06
`define BOC_CLK_FORCE_SFR   5'h08
`define BOC_CLK_FORCE_HL    5'h06
`define BOC_CLK_FORCE_HLS   5'h08
`define BOC_CLK_CARRY       5'h02
`define BOC_CLK_CALL        5'h07
`define BOC_CLK_PAGE_CALL   5'h05
`define BOC_CLK_SIX         5'h06

`endif

// [logic/boc_pkg.sv]
package boc_pkg;

   // instruction groups carried out by this unit
   typedef enum logic [3:0] {
      BOC_CARRY_BIT_AND       = 4'h0,
      BOC_CARRY_BIT_OR        = 4'h1,
      BOC_CARRY_BIT_EXCLUSIVE = 4'h2,
      BOC_BIT_FORCE_HIGH      = 4'h3,
      BOC_BIT_FORCE_LOW       = 4'h4,
      BOC_CARRY_FORCE_HIGH    = 4'h5,
      BOC_CARRY_FORCE_LOW     = 4'h6,
      BOC_CARRY_INVERT        = 4'h7,
      BOC_ABSOLUTE_CALL       = 4'h8,
      BOC_SHORT_PAGE_CALL     = 4'h9,
      BOC_VECTOR_TABLE_CALL   = 4'ha,
      BOC_SOFTWARE_BREAK_TRAP = 4'hb,
      BOC_POP_PC_BACK         = 4'hc
   } boc_op_type;

   // operand location of a bit instruction
   typedef enum logic [2:0] {
      BOC_FORM_SADDR = 3'h0,
      BOC_FORM_SFR   = 3'h1,
      BOC_FORM_ACC   = 3'h2,
      BOC_FORM_PSW   = 3'h3,
      BOC_FORM_HL    = 3'h4
   } boc_form_type;

   typedef enum logic [1:0] {
      BOC_IDLE = 2'b01,
      BOC_RUN  = 2'b10
   } boc_state_type;

endpackage : boc_pkg
